// ===== design/cppo_defines.svh
// Register offsets, field positions, reset values and codes for the override block
`ifndef CPPO_DEFINES_SVH
`define CPPO_DEFINES_SVH

`define CPPO_ADDR_W         8
`define CPPO_OFF_CTRL       8'h00
`define CPPO_OFF_STAT       8'h04
`define CPPO_OFF_INT        8'h08
`define CPPO_OFF_INT_EN     8'h0C

`define CPPO_CTRL_DCDC_OFF  0
`define CPPO_CTRL_BSW_OFF   1
`define CPPO_CTRL_JEITA     2
`define CPPO_CTRL_CHG_EN    3
`define CPPO_CTRL_MODE_LSB  4
`define CPPO_CTRL_MODE_MSB  7
`define CPPO_CTRL_RST       8'h08
`define CPPO_CTRL_W         8

`define CPPO_MODE_REV_BUCK  4'hA

`define CPPO_INT_W          3
`define CPPO_INT_SUSP       0
`define CPPO_INT_RESUME     1
`define CPPO_INT_REMOVED    2
`define CPPO_INT_EN_RST     3'h0

`define CPPO_DTL_OFF        4'h8
`define CPPO_DTL_CHARGING   4'h1
`define CPPO_DTL_SUSP       4'h5
`define CPPO_DTL_NO_BATT    4'h6

`define CPPO_SYNC_STAGES    2

`endif

// ===== design/cppo_pkg.sv
// Types shared by the override block
package cppo_pkg;
  typedef enum logic [1:0] {
    CHG_OFF,
    CHG_RUN,
    CHG_SUSP,
    CHG_NOBAT
  } cppo_state_type;
endpackage

// ===== design/cppo_sync.sv
// Two-flop synchroniser for the override pins
module cppo_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ===== design/cppo_core.sv
// Power-path override, thermal suspension and APB register file
`include "cppo_defines.svh"

// Operation
// - DC-DC off when pin or bit set
// - Otherwise DC-DC follows power-path state machine
// - Switch-off pin or bit disables switch, charging
// - Overrides OR pin and bit; reverse-buck wins
// - DC-DC-off alone: switch on, DC-DC off
// - Both switch-off and DC-DC-off: both off
// - Out-of-range temperature stops charging
// - Suspension resets timers, reports, raises event
// - Back in range: resume, restart timer
// - Temperature-dependent charging only when enabled
// - Sense tied high means battery removed
// - Sense grounded disables monitoring and JEITA
// - Sense grounded: auto-charge with valid adapter
// - Cell count 2 or 3 latched once
// - Bad programming inputs: regulate, no charging
module cppo_core (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`CPPO_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    dcdc_off_pin,
  input  wire logic                    batt_switch_off_pin,
  input  wire logic                    reverse_buck_pin,
  input  wire logic                    pps_batt_switch_en,
  input  wire logic                    pps_dcdc_en,
  input  wire logic                    temp_cold,
  input  wire logic                    temp_hot,
  input  wire logic                    temp_sense_at_rail,
  input  wire logic                    temp_sense_grounded,
  input  wire logic                    adapter_valid,
  input  wire logic                    cell_count_input,
  input  wire logic                    prog_inputs_ok,
  output logic                         battery_switch,
  output logic                         dcdc_en,
  output logic                         charge_en,
  output logic                         charge_timer_rst,
  output logic                         jeita_active,
  output logic                         cells_3s,
  output cppo_pkg::cppo_state_type     charge_state,
  output logic                         irq
);
  import cppo_pkg::*;

  logic [2:0]               pin_s;
  logic                     rb_ovr;
  logic                     bo_ovr;
  logic                     do_ovr;
  logic [`CPPO_CTRL_W-1:0]  ctrl_r;
  logic [`CPPO_INT_W-1:0]   int_stat_r;
  logic [`CPPO_INT_W-1:0]   int_stat_nxt;
  logic [`CPPO_INT_W-1:0]   int_en_r;
  logic [`CPPO_INT_W-1:0]   int_evt;
  logic [3:0]               detail_r;
  logic                     battery_switch_r;
  logic                     dcdc_en_r;
  logic                     charge_en_r;
  logic                     timer_rst_r;
  logic                     jeita_active_r;
  logic                     cells_3s_r;
  logic                     cfg_taken_r;
  logic [31:0]              prdata_r;
  cppo_state_type           state_r;
  cppo_state_type           state_nxt;
  logic                     therm_fault;
  logic                     removed;
  logic                     charge_allow;
  logic                     jeita_ok;
  logic                     wr_en;
  logic                     rd_setup;

  function automatic logic addr_hit(input logic [`CPPO_ADDR_W-1:0] a);
    addr_hit = (a == `CPPO_OFF_CTRL) || (a == `CPPO_OFF_STAT) ||
               (a == `CPPO_OFF_INT)  || (a == `CPPO_OFF_INT_EN);
  endfunction

  function automatic logic [3:0] detail_of(input cppo_state_type s);
    case (s)
      CHG_RUN:   detail_of = `CPPO_DTL_CHARGING;
      CHG_SUSP:  detail_of = `CPPO_DTL_SUSP;
      CHG_NOBAT: detail_of = `CPPO_DTL_NO_BATT;
      default:   detail_of = `CPPO_DTL_OFF;
    endcase
  endfunction

  // Pins come from another supply domain and may glitch against the bits
  cppo_sync #(
    .W (3)
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({reverse_buck_pin, batt_switch_off_pin, dcdc_off_pin}),
    .q     (pin_s)
  );

  assign rb_ovr = pin_s[2] |
                  (ctrl_r[`CPPO_CTRL_MODE_MSB:`CPPO_CTRL_MODE_LSB] == `CPPO_MODE_REV_BUCK);
  assign bo_ovr = pin_s[1] | ctrl_r[`CPPO_CTRL_BSW_OFF];
  assign do_ovr = pin_s[0] | ctrl_r[`CPPO_CTRL_DCDC_OFF];

  // Switch and converter steering
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      battery_switch_r <= 1'b0;
      dcdc_en_r        <= 1'b0;
    end else if (rb_ovr) begin
      battery_switch_r <= 1'b1;
      dcdc_en_r        <= pps_dcdc_en;
    end else begin
      case ({bo_ovr, do_ovr})
        2'b00: begin
          battery_switch_r <= pps_batt_switch_en;
          dcdc_en_r        <= pps_dcdc_en;
        end
        2'b01: begin
          battery_switch_r <= 1'b1;
          dcdc_en_r        <= 1'b0;
        end
        2'b10: begin
          battery_switch_r <= 1'b0;
          dcdc_en_r        <= pps_dcdc_en;
        end
        default: begin
          battery_switch_r <= 1'b0;
          dcdc_en_r        <= 1'b0;
        end
      endcase
    end
  end

  // Cell count strap caught once, on the first edge after reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_taken_r <= 1'b0;
      cells_3s_r  <= 1'b0;
    end else if (!cfg_taken_r) begin
      cfg_taken_r <= 1'b1;
      cells_3s_r  <= cell_count_input;
    end
  end

  // A grounded sense pin masks the comparators entirely
  assign therm_fault  = !temp_sense_grounded && (temp_cold || temp_hot);
  assign removed      = temp_sense_at_rail && !temp_sense_grounded;
  assign charge_allow = adapter_valid && ctrl_r[`CPPO_CTRL_CHG_EN] && prog_inputs_ok &&
                        !bo_ovr && !do_ovr && !rb_ovr;
  assign jeita_ok     = ctrl_r[`CPPO_CTRL_JEITA] && !temp_sense_grounded;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CHG_OFF: begin
        if (removed) begin
          state_nxt = CHG_NOBAT;
        end else if (charge_allow) begin
          state_nxt = therm_fault ? CHG_SUSP : CHG_RUN;
        end
      end
      CHG_RUN: begin
        if (removed) begin
          state_nxt = CHG_NOBAT;
        end else if (!charge_allow) begin
          state_nxt = CHG_OFF;
        end else if (therm_fault) begin
          state_nxt = CHG_SUSP;
        end
      end
      CHG_SUSP: begin
        if (removed) begin
          state_nxt = CHG_NOBAT;
        end else if (!charge_allow) begin
          state_nxt = CHG_OFF;
        end else if (!therm_fault) begin
          state_nxt = CHG_RUN;
        end
      end
      CHG_NOBAT: begin
        if (!removed) begin
          state_nxt = CHG_OFF;
        end
      end
      default: state_nxt = CHG_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r        <= CHG_OFF;
      charge_en_r    <= 1'b0;
      timer_rst_r    <= 1'b0;
      detail_r       <= `CPPO_DTL_OFF;
      jeita_active_r <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      charge_en_r    <= (state_nxt == CHG_RUN);
      // Timers clear on suspension and again on every fresh start
      timer_rst_r    <= (state_nxt == CHG_SUSP && state_r != CHG_SUSP) ||
                        (state_nxt == CHG_RUN && state_r != CHG_RUN);
      detail_r       <= detail_of(state_nxt);
      jeita_active_r <= jeita_ok;
    end
  end

  // Events and sticky status; a new event beats a same-cycle clear
  assign int_evt[`CPPO_INT_SUSP]    = (state_nxt == CHG_SUSP) && (state_r != CHG_SUSP);
  assign int_evt[`CPPO_INT_RESUME]  = (state_r == CHG_SUSP) && (state_nxt == CHG_RUN);
  assign int_evt[`CPPO_INT_REMOVED] = (state_nxt == CHG_NOBAT) && (state_r != CHG_NOBAT);

  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    int_stat_nxt = int_stat_r;
    if (wr_en && paddr == `CPPO_OFF_INT) begin
      int_stat_nxt = int_stat_r & ~pwdata[`CPPO_INT_W-1:0];
    end
    int_stat_nxt = int_stat_nxt | int_evt;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_r <= '0;
    end else begin
      int_stat_r <= int_stat_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r   <= `CPPO_CTRL_RST;
      int_en_r <= `CPPO_INT_EN_RST;
    end else if (wr_en) begin
      if (paddr == `CPPO_OFF_CTRL) begin
        ctrl_r <= pwdata[`CPPO_CTRL_W-1:0];
      end
      if (paddr == `CPPO_OFF_INT_EN) begin
        int_en_r <= pwdata[`CPPO_INT_W-1:0];
      end
    end
  end

  // Read data captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h00000000;
    end else if (rd_setup) begin
      case (paddr)
        `CPPO_OFF_CTRL:   prdata_r <= {24'h000000, ctrl_r};
        `CPPO_OFF_STAT:   prdata_r <= {21'h000000, !prog_inputs_ok, therm_fault,
                                       jeita_active_r, cells_3s_r, dcdc_en_r,
                                       battery_switch_r, charge_en_r, detail_r};
        `CPPO_OFF_INT:    prdata_r <= {29'h00000000, int_stat_r};
        `CPPO_OFF_INT_EN: prdata_r <= {29'h00000000, int_en_r};
        default:          prdata_r <= 32'h00000000;
      endcase
    end
  end

  assign prdata           = prdata_r;
  assign pready           = psel && penable;
  assign pslverr          = psel && penable && !addr_hit(paddr);
  assign battery_switch   = battery_switch_r;
  assign dcdc_en          = dcdc_en_r;
  assign charge_en        = charge_en_r;
  assign charge_timer_rst = timer_rst_r;
  assign jeita_active     = jeita_active_r;
  assign cells_3s         = cells_3s_r;
  assign charge_state     = state_r;
  assign irq              = |(int_stat_r & int_en_r);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  dcdc_forced_off_a: assert property (do_ovr && !rb_ovr |=> !dcdc_en_r)
    else $error("converter on while dcdc-off override active");
  dcdc_handback_a: assert property ((!do_ovr || rb_ovr) |=> dcdc_en_r == $past(pps_dcdc_en))
    else $error("converter not following power-path control");
  bsw_off_a: assert property (bo_ovr && !rb_ovr |=> !battery_switch_r && !charge_en_r)
    else $error("switch or charging on under switch-off override");
  rev_buck_a: assert property (rb_ovr |=> battery_switch_r &&
                               dcdc_en_r == $past(pps_dcdc_en))
    else $error("reverse-buck override not honoured");
  pin_sync_a: assert property ($rose(dcdc_off_pin) ##1 dcdc_off_pin |=> pin_s[0])
    else $error("override pin not through two stages");
  dcdc_off_pin_only_a: assert property (do_ovr && !bo_ovr && !rb_ovr |=>
                                battery_switch_r && !dcdc_en_r)
    else $error("battery feed not forced under dcdc-off");
  both_off_a: assert property (do_ovr && bo_ovr && !rb_ovr |=>
                               !battery_switch_r && !dcdc_en_r)
    else $error("switch or converter on with both overrides");
  therm_stop_a: assert property (therm_fault |=> !charge_en_r)
    else $error("charging while temperature out of range");
  susp_entry_a: assert property (int_evt[`CPPO_INT_SUSP] |=> timer_rst_r &&
                                 int_stat_r[`CPPO_INT_SUSP] &&
                                 detail_r == `CPPO_DTL_SUSP && !charge_en_r)
    else $error("suspension entry not reported");
  resume_a: assert property (state_r == CHG_SUSP && state_nxt == CHG_RUN
                             |=> charge_en_r && timer_rst_r)
    else $error("resume without timer restart");
  jeita_gate_a: assert property (##1 jeita_active_r == ($past(ctrl_r[`CPPO_CTRL_JEITA])
                                 && !$past(temp_sense_grounded)))
    else $error("jeita state does not follow enable");
  removed_a: assert property (removed |=> !charge_en_r && state_r == CHG_NOBAT)
    else $error("charging with battery removed");
  gnd_monitor_a: assert property (temp_sense_grounded |=> !jeita_active_r)
    else $error("jeita active with grounded sense");
  // Leaving the no-battery state costs one pass through off first
  gnd_auto_a: assert property (temp_sense_grounded && charge_allow && state_r != CHG_NOBAT
                               |=> charge_en_r)
    else $error("no automatic charge with grounded sense");
  cells_hold_a: assert property (cfg_taken_r |=> $stable(cells_3s_r))
    else $error("cell count changed after configuration");
  bad_prog_a: assert property (!prog_inputs_ok && !do_ovr && !rb_ovr && !bo_ovr
                               |=> !charge_en_r && dcdc_en_r == $past(pps_dcdc_en))
    else $error("charging with bad programming inputs");
endmodule

// ===== testbench/cppo_host.sv
// Host model that drives the three override pins
module cppo_host (
  input  wire logic       clk,
  input  wire logic [2:0] req,
  input  wire logic [1:0] dly,
  output logic      [2:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_r  = 2'h0;
  logic [2:0] pins_r = 3'h0;
  assign pins = pins_r;
  // A slow host shows a new pin pattern only dly+1 cycles after it is asked for
  always @(posedge clk) begin
    if (req == pins_r) begin
      cnt_r <= 2'h0;
    end else if (cnt_r >= dly) begin
      pins_r <= req;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the override and thermal suspension block
`include "cppo_defines.svh"
module tb_top;
  import cppo_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [3:0] sel; logic [31:0] exp;} cppo_note_type;
  logic           clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]     paddr = 8'h00;
  logic [31:0]    pwdata = 32'h0, prdata;
  logic           pready, pslverr, bsw_o, dcdc_en, charge_en, timer_rst, jeita_o, cells_3s, irq;
  logic           pps_b = 1'b0, pps_d = 1'b0, cold = 1'b0, hot = 1'b0, at_rail = 1'b0;
  logic           gnd = 1'b0, adapter = 1'b0, cell_in = 1'b1, prog_ok = 1'b1;
  logic [2:0]     host_req = 3'h0, pins;
  logic [1:0]     host_dly = 2'h0;
  logic [15:0]    rnd = 16'hEC6E;
  cppo_state_type charge_state;
  cppo_note_type  notes[$];
  int             err_total = 0, tests_run = 0;

  always #5 clk = ~clk;

  cppo_host host (.clk(clk), .req(host_req), .dly(host_dly), .pins(pins));

  cppo_core dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dcdc_off_pin(pins[0]), .batt_switch_off_pin(pins[1]), .reverse_buck_pin(pins[2]),
    .pps_batt_switch_en(pps_b), .pps_dcdc_en(pps_d), .temp_cold(cold), .temp_hot(hot),
    .temp_sense_at_rail(at_rail), .temp_sense_grounded(gnd), .adapter_valid(adapter),
    .cell_count_input(cell_in), .prog_inputs_ok(prog_ok), .battery_switch(bsw_o),
    .dcdc_en(dcdc_en), .charge_en(charge_en), .charge_timer_rst(timer_rst),
    .jeita_active(jeita_o), .cells_3s(cells_3s), .charge_state(charge_state), .irq(irq)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [31:0] pick(input logic [3:0] s);
    case (s)
      4'h0: return prdata;
      4'h1: return {31'h0, pslverr};
      4'h2: return {30'h0, bsw_o, dcdc_en};
      4'h3: return {31'h0, charge_en};
      4'h4: return {31'h0, timer_rst};
      4'h5: return {31'h0, irq};
      4'h6: return {30'h0, charge_state};
      4'h7: return {31'h0, cells_3s};
      4'h8: return {31'h0, jeita_o};
      default: return {31'h0, pready};
    endcase
  endfunction

  // Expected {switch, converter} for o = {reverse, switch-off, converter-off}
  function automatic logic [1:0] ovr(input logic [2:0] o);
    if (o[2]) return {1'b1, pps_d};
    if (o[1]) return {1'b0, o[0] ? 1'b0 : pps_d};
    if (o[0]) return 2'b10;
    return {pps_b, pps_d};
  endfunction

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task chk(input logic [3:0] s, input logic [31:0] e);
    notes.push_back('{s, e});
  endtask

  // Ends between edges so a note is compared at the following rising edge
  task settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
           input logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(negedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) err_total++;
    if (!w) chk(4'h0, e);
    chk(4'h1, {31'h0, err});
    chk(4'h9, 32'h1);
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Values are taken before the edge's own updates land
  always @(posedge clk) begin
    cppo_note_type n;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      check(pick(n.sel), n.exp);
    end
  end

  initial begin
    #50us;
    err_total++;
    end_sim();
  end

  initial begin
    logic [2:0] o;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `CPPO_OFF_CTRL, 32'h0, {24'h0, `CPPO_CTRL_RST}, 1'b0);
    apb(1'b0, `CPPO_OFF_INT_EN, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
    apb(1'b1, `CPPO_OFF_STAT, 32'hFFFF, 32'h0, 1'b0);
    adapter <= 1'b1;
    $display("test registers done");
    // Upper half drives the pins through the host, lower half the bits
    for (int j = 0; j < 16; j++) begin
      o = j[2:0];
      rnd = lfsr(rnd);
      @(posedge clk);
      pps_b <= rnd[0];
      pps_d <= rnd[1];
      host_dly <= rnd[3:2];
      host_req <= j[3] ? o : 3'h0;
      apb(1'b1, `CPPO_OFF_CTRL, {24'h0, (o[2] && !j[3]) ? `CPPO_MODE_REV_BUCK : 4'h0, 2'b10,
          j[3] ? 2'b00 : o[1:0]}, 32'h0, 1'b0);
      settle(6);
      chk(4'h2, {30'h0, ovr(o)});
      chk(4'h3, {31'h0, o == 3'h0});
    end
    @(posedge clk);
    host_req <= 3'h0;
    pps_b <= 1'b1;
    pps_d <= 1'b1;
    apb(1'b1, `CPPO_OFF_CTRL, 32'h08, 32'h0, 1'b0);
    $display("test overrides done");
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `CPPO_OFF_INT_EN, k ? 32'h7 : 32'h0, 32'h0, 1'b0);
      settle(6);
      chk(4'h3, 32'h1);
      @(posedge clk);
      if (k) cold <= 1'b1;
      else hot <= 1'b1;
      settle(1);
      chk(4'h4, 32'h1);
      chk(4'h3, 32'h0);
      chk(4'h6, {30'h0, CHG_SUSP});
      chk(4'h5, {31'h0, k[0]});
      settle(1);
      chk(4'h4, 32'h0);
      apb(1'b0, `CPPO_OFF_STAT, 32'h0, {28'h2E, `CPPO_DTL_SUSP}, 1'b0);
      apb(1'b0, `CPPO_OFF_INT, 32'h0, 32'h1, 1'b0);
      apb(1'b1, `CPPO_OFF_INT, 32'h1, 32'h0, 1'b0);
      cold <= 1'b0;
      hot <= 1'b0;
      settle(1);
      chk(4'h4, 32'h1);
      chk(4'h3, 32'h1);
      apb(1'b0, `CPPO_OFF_INT, 32'h0, 32'h2, 1'b0);
      apb(1'b1, `CPPO_OFF_INT, 32'h7, 32'h0, 1'b0);
      settle(1);
      chk(4'h5, 32'h0);
    end
    $display("test thermal done");
    apb(1'b1, `CPPO_OFF_CTRL, 32'h0C, 32'h0, 1'b0);
    settle(2);
    chk(4'h8, 32'h1);
    @(posedge clk);
    gnd <= 1'b1;
    hot <= 1'b1;
    settle(3);
    chk(4'h8, 32'h0);
    chk(4'h3, 32'h1);
    @(posedge clk);
    gnd <= 1'b0;
    hot <= 1'b0;
    at_rail <= 1'b1;
    settle(2);
    chk(4'h6, {30'h0, CHG_NOBAT});
    chk(4'h3, 32'h0);
    chk(4'h5, 32'h1);
    @(posedge clk);
    at_rail <= 1'b0;
    prog_ok <= 1'b0;
    cell_in <= 1'b0;
    settle(5);
    chk(4'h3, 32'h0);
    chk(4'h2, 32'h3);
    chk(4'h7, 32'h1);
    settle(1);
    $display("test sense and strap done");
    end_sim();
  end
endmodule
